// [design/kwdt_cfg.svh]
`ifndef KWDT_CFG_SVH
`define KWDT_CFG_SVH

// register byte offsets
`define KWDT_OFF_WATCHDOG_CONTROL 8'h00
`define KWDT_OFF_CTRL 8'h04
`define KWDT_OFF_ISTAT 8'h08
`define KWDT_OFF_ICLR 8'h0C
`define KWDT_OFF_IEN 8'h10
`define KWDT_OFF_WSTAT 8'h14

// watchdog_control layout and power-on value
`define KWDT_WATCHDOG_CONTROL_RESET 8'h53
`define KWDT_KEY_MSB 7
`define KWDT_KEY_LSB 3
`define KWDT_SEL_MSB 2
`define KWDT_SEL_LSB 0
`define KWDT_KEY_DISABLE 5'h15
`define KWDT_KEY_ENABLE 5'h0A

// system_control_flags layout
`define KWDT_CTRL_RESET 8'h00
`define KWDT_CTRL_KEEP_BIT 7
`define KWDT_CTRL_LOWVOLT_RESET_FLAG_BIT 2
`define KWDT_CTRL_LRF_BIT 1
`define KWDT_CTRL_WRF_BIT 0

// interrupt event bit positions
`define KWDT_EVT_TIMEOUT 0
`define KWDT_EVT_KEYRST 1
`define KWDT_EVT_LOWVOLT 2

// timing
`define KWDT_SYS_HZ 20000000
`define KWDT_SUB_HZ 32000
`define KWDT_SUB_DIV ((`KWDT_SYS_HZ + `KWDT_SUB_HZ / 2) / `KWDT_SUB_HZ)
`define KWDT_KEY_DELAY_TICKS 2

`define KWDT_RESP_OKAY 2'h0
`define KWDT_RESP_SLVERR 2'h2

`endif

// [design/kwdt_pkg.sv]
package kwdt_pkg;

    typedef struct packed {
        logic lowvolt;
        logic key_reset;
        logic timeout;
    } kwdt_evt_s;

    typedef enum logic [2:0] {
        KM_IDLE = 3'b001,
        KM_WAIT1 = 3'b010,
        KM_WAIT2 = 3'b100
    } kwdt_keymon_e;

    typedef logic [4:0] kwdt_exp_t;

    function automatic kwdt_exp_t kwdt_exponent(input logic [2:0] sel);
        kwdt_exp_t e;
        unique case (sel)
            3'h0: e = 5'h08;
            3'h1: e = 5'h0A;
            3'h2: e = 5'h0C;
            3'h3: e = 5'h0E;
            3'h4: e = 5'h0F;
            3'h5: e = 5'h10;
            3'h6: e = 5'h11;
            3'h7: e = 5'h12;
        endcase
        return e;
    endfunction : kwdt_exponent

endpackage : kwdt_pkg

// [design/kwdt_subclk.sv]
`timescale 1ns/1ps
`include "kwdt_cfg.svh"

// stands in for the low-speed oscillator: one tick per sub-clock period
module kwdt_subclk #(
    parameter int DIV = `KWDT_SUB_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic sub_tick
);
    import kwdt_pkg::*;

    logic [15:0] div_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= 16'h0000;
            sub_tick <= 1'b0;
        end else if (div_reg == 16'(DIV - 1)) begin
            div_reg <= 16'h0000;
            sub_tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 16'h0001;
            sub_tick <= 1'b0;
        end
    end

endmodule : kwdt_subclk

// [design/kwdt_prescaler.sv]
`timescale 1ns/1ps
`include "kwdt_cfg.svh"

module kwdt_prescaler #(
    parameter int CW = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sub_tick,
    input wire logic clear,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic overflow
);
    import kwdt_pkg::*;

    logic [CW-1:0] count_reg;
    logic [CW:0] span;
    logic [CW-1:0] terminal;

    assign span = (CW+1)'(1) << kwdt_exponent(sel);
    assign terminal = CW'(span - (CW+1)'(1));

    // counter held at zero while stopped, so enabling always starts a fresh period
    always_ff @(posedge aclk) begin
        if (!aresetn || clear || !run) begin
            count_reg <= '0;
            overflow <= 1'b0;
        end else if (sub_tick && count_reg >= terminal) begin
            count_reg <= '0;
            overflow <= 1'b1;
        end else begin
            count_reg <= sub_tick ? count_reg + CW'(1) : count_reg;
            overflow <= 1'b0;
        end
    end

endmodule : kwdt_prescaler

// [design/kwdt_top.sv]
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "kwdt_cfg.svh"

module kwdt_top
    import kwdt_pkg::*;
#(
    parameter int AW = 8,
    parameter int SUB_DIV = `KWDT_SUB_DIV,
    parameter int CW = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clear_watchdog_instruction,
    input wire logic halt_instruction,
    input wire logic sleep_idle_mode,
    input wire logic lowvolt_detect,
    input wire logic voltsel_fault,
    output logic device_reset_req,
    output logic pcsp_reset_req,
    output logic timeout_status_flag,
    output logic idle_sysclk_keep,
    output logic irq
);

    logic [7:0] watchdog_control_reg;
    logic [7:0] ctrl_reg;
    kwdt_evt_s istat_reg;
    kwdt_evt_s ien_reg;
    kwdt_evt_s evt;
    kwdt_keymon_e keymon_reg;

    logic [AW-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic wr_fire;
    logic [7:0] wr_off;
    logic [7:0] rd_off;
    logic wr_lane0;

    logic sub_tick;
    logic overflow;
    logic [4:0] enable_key_field;
    logic [2:0] timeout_select;
    logic key_enabled;
    logic key_bad;
    logic key_fire;
    logic wdt_clear;

    // ---------------- sub-clock and prescaler ----------------
    kwdt_subclk #(
        .DIV(SUB_DIV)
    ) u_subclk (
        .aclk(aclk),
        .aresetn(aresetn),
        .sub_tick(sub_tick)
    );

    assign enable_key_field = watchdog_control_reg[`KWDT_KEY_MSB:`KWDT_KEY_LSB];
    assign timeout_select = watchdog_control_reg[`KWDT_SEL_MSB:`KWDT_SEL_LSB];
    assign key_enabled = (enable_key_field == `KWDT_KEY_ENABLE);
    // disable code and bad codes both stop the count; bad codes also arm the reset
    assign key_bad = !key_enabled && (enable_key_field != `KWDT_KEY_DISABLE);
    assign key_fire = sub_tick && (keymon_reg == KM_WAIT2) && key_bad;

    // halt, the clear instruction, any device reset and a key reset restart the period
    assign wdt_clear = clear_watchdog_instruction || halt_instruction || key_fire
        || (overflow && !sleep_idle_mode);

    kwdt_prescaler #(
        .CW(CW)
    ) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .sub_tick(sub_tick),
        .clear(wdt_clear),
        .run(key_enabled),
        .sel(timeout_select),
        .overflow(overflow)
    );

    // ---------------- key monitor ----------------
    // sampling on sub-clock ticks gives 2 to 3 ticks from a bad value to the reset
    // a valid key written before the third observing tick cancels the pending reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keymon_reg <= KM_IDLE;
        end else if (sub_tick) begin
            unique case (keymon_reg)
                KM_IDLE: begin
                    keymon_reg <= key_bad ? KM_WAIT1 : KM_IDLE;
                end
                KM_WAIT1: begin
                    keymon_reg <= key_bad ? KM_WAIT2 : KM_IDLE;
                end
                KM_WAIT2: begin
                    keymon_reg <= KM_IDLE;
                end
            endcase
        end
    end

    // ---------------- reset requests and time-out flag ----------------
    // the requests only leave this block; nothing here is reset by them
    // limitation: looping them into aresetn restarts the whole block, flags included
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            device_reset_req <= 1'b0;
            pcsp_reset_req <= 1'b0;
        end else begin
            device_reset_req <= key_fire || (overflow && !sleep_idle_mode);
            pcsp_reset_req <= overflow && sleep_idle_mode;
        end
    end

    // a time-out arriving with a clear still sets the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_status_flag <= 1'b0;
        end else if (overflow) begin
            timeout_status_flag <= 1'b1;
        end else if (clear_watchdog_instruction || halt_instruction) begin
            timeout_status_flag <= 1'b0;
        end
    end

    // ---------------- AXI4-Lite write channel ----------------
    // a write lands once both halves are held and the previous response has been taken
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_off = {awaddr_reg[7:2], 2'b00};
    assign wr_lane0 = wr_fire && wstrb_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held_reg <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `KWDT_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            unique case (wr_off)
                `KWDT_OFF_WATCHDOG_CONTROL, `KWDT_OFF_CTRL, `KWDT_OFF_ICLR, `KWDT_OFF_IEN: begin
                    s_axi_bresp <= `KWDT_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `KWDT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------- watchdog_control ----------------
    // a key reset puts the register back to its power-on value so the device restarts enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_control_reg <= `KWDT_WATCHDOG_CONTROL_RESET;
        end else if (key_fire) begin
            watchdog_control_reg <= `KWDT_WATCHDOG_CONTROL_RESET;
        end else if (wr_lane0 && wr_off == `KWDT_OFF_WATCHDOG_CONTROL) begin
            watchdog_control_reg <= wdata_reg[7:0];
        end
    end

    // ---------------- system_control_flags ----------------
    // bits 6..3 are unimplemented and always read back as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `KWDT_CTRL_RESET;
        end else begin
            if (wr_lane0 && wr_off == `KWDT_OFF_CTRL) begin
                ctrl_reg <= wdata_reg[7:0] & 8'h87;
            end
            // hardware sets win over a software write in the same cycle
            if (key_fire) begin
                ctrl_reg[`KWDT_CTRL_WRF_BIT] <= 1'b1;
            end
            if (lowvolt_detect) begin
                ctrl_reg[`KWDT_CTRL_LOWVOLT_RESET_FLAG_BIT] <= 1'b1;
            end
            if (voltsel_fault) begin
                ctrl_reg[`KWDT_CTRL_LRF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_sysclk_keep <= 1'b0;
        end else if (wr_lane0 && wr_off == `KWDT_OFF_CTRL) begin
            idle_sysclk_keep <= wdata_reg[`KWDT_CTRL_KEEP_BIT];
        end
    end

    // ---------------- interrupt status, enable, clear ----------------
    assign evt.timeout = overflow;
    assign evt.key_reset = key_fire;
    assign evt.lowvolt = lowvolt_detect;

    // one sticky bit per event; an event in the same cycle as its clear keeps the bit set
    for (genvar i = 0; i < 3; i++) begin : g_istat
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                istat_reg[i] <= 1'b0;
            end else if (evt[i]) begin
                istat_reg[i] <= 1'b1;
            end else if (wr_lane0 && wr_off == `KWDT_OFF_ICLR && wdata_reg[i]) begin
                istat_reg[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // enables gate only the level output; status still records every event
            ien_reg <= '0;
        end else if (wr_lane0 && wr_off == `KWDT_OFF_IEN) begin
            ien_reg <= wdata_reg[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_reg & ien_reg);
        end
    end

    // ---------------- AXI4-Lite read channel ----------------
    // the read address is decoded at its handshake, so the data reflect that edge
    assign rd_off = {s_axi_araddr[7:2], 2'b00};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `KWDT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `KWDT_RESP_OKAY;
            unique case (rd_off)
                `KWDT_OFF_WATCHDOG_CONTROL: begin
                    s_axi_rdata <= {24'h000000, watchdog_control_reg};
                end
                `KWDT_OFF_CTRL: begin
                    s_axi_rdata <= {24'h000000, ctrl_reg};
                end
                `KWDT_OFF_ISTAT: begin
                    s_axi_rdata <= {29'h00000000, istat_reg};
                end
                `KWDT_OFF_ICLR: begin
                    s_axi_rdata <= 32'h0000_0000;
                end
                `KWDT_OFF_IEN: begin
                    s_axi_rdata <= {29'h00000000, ien_reg};
                end
                `KWDT_OFF_WSTAT: begin
                    s_axi_rdata <= {27'h0000000, keymon_reg, timeout_status_flag, key_enabled};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `KWDT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : kwdt_top

// [verification/kwdt_top_assertions.sv]
`timescale 1ns/1ps

module kwdt_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clear_watchdog_instruction,
    input wire logic halt_instruction,
    input wire logic device_reset_req,
    input wire logic pcsp_reset_req,
    input wire logic timeout_status_flag,
    input wire logic idle_sysclk_keep
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_dev_pulse;
        device_reset_req |=> !device_reset_req;
    endproperty
    a_dev_pulse: assert property (p_dev_pulse) else $error("device reset request too long");
    property p_pcsp_pulse;
        pcsp_reset_req |=> !pcsp_reset_req;
    endproperty
    a_pcsp_pulse: assert property (p_pcsp_pulse) else $error("pc/sp reset request too long");
    property p_pcsp_flag;
        pcsp_reset_req && !clear_watchdog_instruction && !halt_instruction |=> timeout_status_flag;
    endproperty
    a_pcsp_flag: assert property (p_pcsp_flag) else $error("time-out flag missing after pc/sp reset");
    property p_one_kind;
        !(device_reset_req && pcsp_reset_req);
    endproperty
    a_one_kind: assert property (p_one_kind) else $error("both reset kinds at once");
    property p_flag_cause;
        $rose(timeout_status_flag) |-> device_reset_req || pcsp_reset_req || $past(device_reset_req)
            || $past(pcsp_reset_req);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("time-out flag set without time-out");
    property p_flag_clear;
        clear_watchdog_instruction || halt_instruction
            |=> !timeout_status_flag || device_reset_req || pcsp_reset_req;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("time-out flag not cleared");
    property p_keep_stable;
        !s_axi_bvalid |-> $stable(idle_sysclk_keep);
    endproperty
    a_keep_stable: assert property (p_keep_stable) else $error("clock keep bit moved without a write");
    property p_b_after_w;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b_after_w: assert property (p_b_after_w) else $error("write response late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule : kwdt_checker

bind kwdt_top kwdt_checker kwdt_checker_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .clear_watchdog_instruction(clear_watchdog_instruction),
    .halt_instruction(halt_instruction), .device_reset_req(device_reset_req), .pcsp_reset_req(pcsp_reset_req),
    .timeout_status_flag(timeout_status_flag), .idle_sysclk_keep(idle_sysclk_keep));

// [verification/kwdt_top_bench.sv]
`timescale 1ns/1ps

module kwdt_top_bench;
    // short sub-clock so the longer selects fit in the run
    localparam int D = 4;
    logic aclk = 1'b0;
    logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, ev;
    logic [1:0] bresp, rresp;
    logic sleep, dev_req, pc_req, to_flag, keep, irq;
    int dev_cnt, pc_cnt, bad_count, tests_run, n;

    kwdt_top #(.SUB_DIV(D)) kwdt_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clear_watchdog_instruction(ev[0]),
        .halt_instruction(ev[1]), .sleep_idle_mode(sleep), .lowvolt_detect(ev[2]), .voltsel_fault(ev[3]),
        .device_reset_req(dev_req), .pcsp_reset_req(pc_req), .timeout_status_flag(to_flag),
        .idle_sysclk_keep(keep), .irq(irq));

    always #25 aclk = ~aclk;

    always @(posedge aclk) begin
        if (dev_req === 1'b1) dev_cnt <= dev_cnt + 1;
        if (pc_req === 1'b1) pc_cnt <= pc_cnt + 1;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check("bresp", 32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        if (er == 2'h0) check("rdata", rdata, ex);
        check("rresp", 32'(rresp), 32'(er));
        rready <= 1'b0;
    endtask : rd

    task automatic pulse(input int k);
        @(posedge aclk);
        ev[k] <= 1'b1;
        @(posedge aclk);
        ev[k] <= 1'b0;
        // one more edge so the caller reads what the pulse caused, not the value before it
        @(posedge aclk);
    endtask : pulse

    // cycles until the next reset request of either kind
    task automatic measure();
        int d0;
        int p0;
        d0 = dev_cnt;
        p0 = pc_cnt;
        n = 0;
        while (dev_cnt == d0 && pc_cnt == p0) begin
            @(posedge aclk);
            n++;
        end
        repeat (2) @(posedge aclk);
    endtask : measure

    task automatic in_range(input int lo, input int hi);
        check("cycles", 32'(n >= lo && n <= hi), 32'h1);
    endtask : in_range

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    initial begin
        repeat (60000) @(posedge aclk);
        bad_count++;
        finish_test();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep} = '0;
        {awaddr, araddr, wdata, ev} = '0;
        wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h53);
        rd(8'h04, 32'h00);
        rd(8'h14, 32'h05);
        rd(8'h0C, 32'h00);
        rd(8'h18, 32'h00, 2'h2);
        wr(8'h18, 32'hFF, 2'h2);
        wr(8'h10, 32'h07);
        for (int s = 0; s < 3; s++) begin
            wr(8'h00, 32'h50 | s);
            pulse(0);
            measure();
            in_range(((1 << (8 + 2 * s)) - 1) * D - 4, (1 << (8 + 2 * s)) * D + 4);
            check("pcsp count", 32'(pc_cnt), 32'h0);
            check("to flag", 32'(to_flag), 32'h1);
            check("irq", 32'(irq), 32'h1);
            rd(8'h08, 32'h01);
            wr(8'h0C, 32'h01);
            pulse(0);
            check("to flag", 32'(to_flag), 32'h0);
            check("irq", 32'(irq), 32'h0);
        end
        sleep <= 1'b1;
        wr(8'h00, 32'h50);
        pulse(1);
        measure();
        in_range(255 * D - 4, 256 * D + 4);
        check("pcsp count", 32'(pc_cnt), 32'h1);
        check("dev count", 32'(dev_cnt), 32'h3);
        check("to flag", 32'(to_flag), 32'h1);
        sleep <= 1'b0;
        pulse(0);
        // clears spaced well inside the 2^8 window must keep it quiet
        repeat (4) begin
            repeat (800) @(posedge aclk);
            pulse(0);
        end
        check("dev count", 32'(dev_cnt), 32'h3);
        wr(8'h00, 32'hA8);
        repeat (2000) @(posedge aclk);
        check("dev count", 32'(dev_cnt), 32'h3);
        rd(8'h14, 32'h04);
        wr(8'h00, 32'h50);
        measure();
        in_range(255 * D - 4, 256 * D + 4);
        wr(8'h0C, 32'h07);
        for (int i = 0; i < 2; i++) begin
            wr(8'h00, i ? 32'hB0 : 32'h00);
            measure();
            in_range(D, 3 * D + 4);
            rd(8'h00, 32'h53);
            rd(8'h04, 32'h01);
            rd(8'h08, 32'h02);
            wr(8'h0C, 32'h07);
            wr(8'h04, 32'h00);
            rd(8'h04, 32'h00);
        end
        check("dev count", 32'(dev_cnt), 32'h6);
        wr(8'h00, 32'hAF);
        rd(8'h00, 32'hAF);
        wr(8'h04, 32'hFF);
        rd(8'h04, 32'h87);
        check("keep", 32'(keep), 32'h1);
        wstrb <= 4'h0;
        wr(8'h04, 32'h00);
        wstrb <= 4'hF;
        rd(8'h04, 32'h87);
        wr(8'h04, 32'h00);
        check("keep", 32'(keep), 32'h0);
        wr(8'h10, 32'h00);
        pulse(2);
        pulse(3);
        rd(8'h04, 32'h06);
        rd(8'h08, 32'h04);
        check("irq", 32'(irq), 32'h0);
        wr(8'h10, 32'h04);
        repeat (2) @(posedge aclk);
        check("irq", 32'(irq), 32'h1);
        wr(8'h0C, 32'h04);
        repeat (2) @(posedge aclk);
        check("irq", 32'(irq), 32'h0);
        rd(8'h08, 32'h00);
        finish_test();
    end
endmodule : kwdt_top_bench
